// ### rtl/data_move_instruction_exec.v
// Data-move instruction execution unit with an APB register port.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "data_move_map.vh"
module data_move_instruction_exec #(
    parameter MEM_AW = 7
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg [7:0] working_reg,
    output reg zero_flag,
    output reg [4:0] bank_select_reg,
    output reg [6:0] pc_high_latch
);
    // Classifies a 14-bit instruction word; used for execution only, readback returns the raw word.
    function [2:0] op_class;
        input [13:0] i;
        begin
            if ((i & `M_COPY) == `P_COPY) begin
                op_class = `CL_COPY;
            end else if ((i & `M_STORE) == `P_STORE) begin
                op_class = `CL_STORE;
            end else if ((i & `M_BANK) == `P_BANK) begin
                op_class = `CL_BANK;
            end else if ((i & `M_IND) == `P_IND) begin
                op_class = `CL_IND;
            end else if ((i & `M_REL) == `P_REL) begin
                op_class = `CL_REL;
            end else if ((i & `M_LATCH) == `P_LATCH) begin
                op_class = `CL_LATCH;
            end else if ((i & `M_LIT) == `P_LIT) begin
                op_class = `CL_LIT;
            end else begin
                op_class = `CL_NONE;
            end
        end
    endfunction

    // True when an address is one of the mapped register offsets.
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `OFF_INSTR) || (a == `OFF_WORK) || (a == `OFF_STATUS) ||
                     (a == `OFF_BANK) || (a == `OFF_PCLATCH) || (a == `OFF_PTR0) ||
                     (a == `OFF_PTR1) || (a == `OFF_MEM_ADDR) || (a == `OFF_MEM_DATA);
        end
    endfunction

    // True for both forms of the indirect load; the address mux and the pointers share it.
    function is_indirect;
        input [2:0] c;
        begin
            is_indirect = (c == `CL_IND) || (c == `CL_REL);
        end
    endfunction

    reg [13:0] last_instr;
    reg [15:0] mem_addr;
    wire [15:0] ptr0;
    wire [15:0] ptr1;
    wire [7:0] ram_rdata;

    // The slave never inserts wait states.
    wire access = psel & penable;
    wire wr_acc = access & pwrite & mapped(paddr);
    wire exec = wr_acc & (paddr == `OFF_INSTR);
    wire [13:0] instr = pwdata[13:0];
    wire [2:0] cls = op_class(instr);
    assign pready = 1'b1;
    // Unmapped addresses answer with an error in the access phase.
    assign pslverr = access & ~mapped(paddr);

    // Operand fields of the incoming instruction.
    wire ptr_sel = (cls == `CL_REL) ? instr[`F_REL_SEL] : instr[`F_IND_SEL];
    wire [1:0] mode = instr[1:0];
    wire [5:0] offset = instr[5:0];
    wire [6:0] faddr = instr[6:0];
    wire dir_bit = instr[`F_DIR];
    wire [15:0] ptr = ptr_sel ? ptr1 : ptr0;

    // Pointer arithmetic is 16 bits wide so it wraps on its own.
    wire [15:0] ptr_inc = ptr + 16'h0001;
    wire [15:0] ptr_dec = ptr - 16'h0001;
    wire [15:0] ptr_rel = ptr + {{10{offset[5]}}, offset};

    reg [15:0] ind_ea;
    reg [15:0] next_ptr;
    reg [15:0] dir_ea;
    reg [15:0] ea;

    // Effective address and pointer result of an indirect load.
    always @* begin
        ind_ea = ptr;
        next_ptr = ptr;
        if (cls == `CL_REL) begin
            ind_ea = ptr_rel;
            next_ptr = ptr;
        end else begin
            case (mode)
                `MODE_PRE_INC: begin
                    ind_ea = ptr_inc;
                    next_ptr = ptr_inc;
                end
                `MODE_PRE_DEC: begin
                    ind_ea = ptr_dec;
                    next_ptr = ptr_dec;
                end
                `MODE_POST_INC: begin
                    ind_ea = ptr;
                    next_ptr = ptr_inc;
                end
                `MODE_POST_DEC: begin
                    ind_ea = ptr;
                    next_ptr = ptr_dec;
                end
                default: begin
                    ind_ea = ptr;
                    next_ptr = ptr;
                end
            endcase
        end
    end

    // Direct addresses fold in the bank; window addresses go through a pointer.
    always @* begin
        if (faddr == `WIN0_ADDR) begin
            dir_ea = ptr0;
        end else if (faddr == `WIN1_ADDR) begin
            dir_ea = ptr1;
        end else begin
            dir_ea = {4'h0, bank_select_reg, faddr};
        end
    end

    // One memory port serves both execution and software access.
    always @* begin
        if (exec && is_indirect(cls)) begin
            ea = ind_ea;
        end else if (exec) begin
            ea = dir_ea;
        end else begin
            ea = mem_addr;
        end
    end

    wire ram_we_exec = exec & ((cls == `CL_STORE) | (cls == `CL_COPY & dir_bit));
    wire ram_we_sw = wr_acc & (paddr == `OFF_MEM_DATA);
    reg [7:0] ram_wdata;

    // Software data wins; a store writes the working register and a copy rewrites the byte.
    always @* begin
        if (ram_we_sw) begin
            ram_wdata = pwdata[7:0];
        end else if (cls == `CL_STORE) begin
            ram_wdata = working_reg;
        end else begin
            ram_wdata = ram_rdata;
        end
    end

    // Addresses beyond the memory depth alias onto its low bits.
    file_ram #(
        .AW(MEM_AW),
        .DW(8)
    ) u_ram (
        .pclk(pclk),
        .we(ram_we_exec | ram_we_sw),
        .addr(ea[MEM_AW-1:0]),
        .wdata(ram_wdata),
        .rdata(ram_rdata)
    );

    // Each pointer register follows indirect loads or software writes.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : ptr_g
            reg [15:0] val;
            wire [7:0] off = (g == 0) ? `OFF_PTR0 : `OFF_PTR1;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    val <= `RST_PTR;
                end else if (exec && is_indirect(cls) && ptr_sel == g) begin
                    val <= next_ptr;
                end else if (wr_acc && paddr == off) begin
                    val <= pwdata[15:0];
                end
            end
        end
    endgenerate
    assign ptr0 = ptr_g[0].val;
    assign ptr1 = ptr_g[1].val;

    reg [7:0] next_working_reg;
    reg next_zero_flag;
    reg [4:0] next_bank_select_reg;
    reg [6:0] next_pc_high_latch;
    reg [13:0] next_last_instr;

    // Next values of the core registers; an instruction and a software write never meet.
    always @* begin
        next_working_reg = working_reg;
        next_zero_flag = zero_flag;
        next_bank_select_reg = bank_select_reg;
        next_pc_high_latch = pc_high_latch;
        next_last_instr = last_instr;
        if (exec) begin
            next_last_instr = instr;
            case (cls)
                `CL_COPY: begin
                    if (!dir_bit) begin
                        next_working_reg = ram_rdata;
                    end
                    next_zero_flag = (ram_rdata == 8'h00);
                end
                `CL_IND, `CL_REL: begin
                    next_working_reg = ram_rdata;
                    next_zero_flag = (ram_rdata == 8'h00);
                end
                `CL_BANK: begin
                    next_bank_select_reg = instr[4:0];
                end
                `CL_LATCH: begin
                    next_pc_high_latch = instr[6:0];
                end
                `CL_LIT: begin
                    next_working_reg = instr[7:0];
                end
                default: begin
                    next_working_reg = working_reg;
                end
            endcase
        end else if (wr_acc) begin
            case (paddr)
                `OFF_WORK: next_working_reg = pwdata[7:0];
                `OFF_STATUS: next_zero_flag = pwdata[0];
                `OFF_BANK: next_bank_select_reg = pwdata[4:0];
                `OFF_PCLATCH: next_pc_high_latch = pwdata[6:0];
                default: next_zero_flag = zero_flag;
            endcase
        end
    end

    // Working register, zero flag, bank and latch; every move takes one edge.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            working_reg <= `RST_BYTE;
            zero_flag <= 1'b0;
            bank_select_reg <= `RST_BANK;
            pc_high_latch <= `RST_PCLATCH;
            last_instr <= `RST_INSTR;
        end else begin
            working_reg <= next_working_reg;
            zero_flag <= next_zero_flag;
            bank_select_reg <= next_bank_select_reg;
            pc_high_latch <= next_pc_high_latch;
            last_instr <= next_last_instr;
        end
    end

    // Software pointer into the data memory for loading and checking contents.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr <= `RST_PTR;
        end else if (wr_acc && paddr == `OFF_MEM_ADDR) begin
            mem_addr <= pwdata[15:0];
        end
    end

    reg [31:0] next_prdata;

    // Readback word; narrow registers sit in the low bits and the rest read as zero.
    always @* begin
        next_prdata = 32'h00000000;
        case (paddr)
            `OFF_INSTR: next_prdata = {18'h00000, last_instr};
            `OFF_WORK: next_prdata = {24'h000000, working_reg};
            `OFF_STATUS: next_prdata = {31'h00000000, zero_flag};
            `OFF_BANK: next_prdata = {27'h0000000, bank_select_reg};
            `OFF_PCLATCH: next_prdata = {25'h0000000, pc_high_latch};
            `OFF_PTR0: next_prdata = {16'h0000, ptr0};
            `OFF_PTR1: next_prdata = {16'h0000, ptr1};
            `OFF_MEM_ADDR: next_prdata = {16'h0000, mem_addr};
            `OFF_MEM_DATA: next_prdata = {24'h000000, ram_rdata};
            default: next_prdata = 32'h00000000;
        endcase
    end

    // Read data is captured in the setup phase so it comes from a flip-flop.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end
endmodule // data_move_instruction_exec

// ### rtl/data_move_map.vh
// Constants, offsets and opcode patterns of the data-move execution block.
// Contract
// - Copy-file moves register to working or back
// - Copy-file updates zero flag in both directions
// - Indirect load reads via pointer, sets zero
// - Mode field picks pre/post increment/decrement
// - Relative form adds signed offset, pointer kept
// - Pointer ends plus one, minus one, unchanged
// - Pointers are 16 bits and wrap around
// - Indirect window addresses use the pointer instead
// - Load-bank puts 5-bit literal, flags untouched
// - Load-pc-latch puts 7-bit literal, flags untouched
// - Literal-to-working loads 8 bits, flags untouched
// - Store-working writes working to file register
`ifndef DATA_MOVE_MAP_VH
`define DATA_MOVE_MAP_VH

// Register offsets on the APB (byte addresses).
`define OFF_INSTR 8'h00
`define OFF_WORK 8'h04
`define OFF_STATUS 8'h08
`define OFF_BANK 8'h0C
`define OFF_PCLATCH 8'h10
`define OFF_PTR0 8'h14
`define OFF_PTR1 8'h18
`define OFF_MEM_ADDR 8'h1C
`define OFF_MEM_DATA 8'h20

// Reset values.
`define RST_BYTE 8'h00
`define RST_BANK 5'h00
`define RST_PCLATCH 7'h00
`define RST_PTR 16'h0000
`define RST_INSTR 14'h0000

// Opcode masks and match patterns, 14-bit instruction words.
`define M_COPY 14'h3F00
`define P_COPY 14'h0800
`define M_STORE 14'h3F80
`define P_STORE 14'h0080
`define M_BANK 14'h3FE0
`define P_BANK 14'h0020
`define M_IND 14'h3FF8
`define P_IND 14'h0010
`define M_REL 14'h3F80
`define P_REL 14'h3F00
`define M_LATCH 14'h3F80
`define P_LATCH 14'h3180
`define M_LIT 14'h3F00
`define P_LIT 14'h3000

// Instruction classes from the decoder.
`define CL_NONE 3'h0
`define CL_COPY 3'h1
`define CL_IND 3'h2
`define CL_REL 3'h3
`define CL_BANK 3'h4
`define CL_LATCH 3'h5
`define CL_LIT 3'h6
`define CL_STORE 3'h7

// Pointer mode field codes.
`define MODE_PRE_INC 2'h0
`define MODE_PRE_DEC 2'h1
`define MODE_POST_INC 2'h2
`define MODE_POST_DEC 2'h3

// File addresses that act as the indirect windows.
`define WIN0_ADDR 7'h00
`define WIN1_ADDR 7'h01

// Instruction field positions.
`define F_DIR 7
`define F_IND_SEL 2
`define F_REL_SEL 6

`endif

// ### rtl/file_ram.v
// Byte-wide data memory with asynchronous read and clocked write.
`timescale 1ns/1ps
module file_ram #(
    parameter AW = 7,
    parameter DW = 8
) (
    input wire pclk,
    input wire we,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    output wire [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Read is combinational so a move completes in the same cycle it is issued.
    assign rdata = mem[addr];

    // Memory holds data only, so it is left without reset.
    always @(posedge pclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end
endmodule // file_ram

// ### tb/dm_checker.sv
// Concurrent checks on the ports of the data-move execution block.
`timescale 1ns/1ps
`include "data_move_map.vh"
module dm_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [7:0] working_reg,
    input wire zero_flag,
    input wire [4:0] bank_select_reg,
    input wire [6:0] pc_high_latch
);
    // An instruction runs at the edge that takes a write to the instruction offset.
    wire wr = psel && penable && pwrite;
    wire ex = wr && paddr == `OFF_INSTR;
    wire [13:0] op = pwdata[13:0];
    wire ld = ex && ((op & `M_IND) == `P_IND || (op & `M_REL) == `P_REL);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    lit_load_a: assert property (ex && (op & `M_LIT) == `P_LIT
        |=> working_reg == $past(op[7:0]) && $stable(zero_flag)) else $error("bad literal");
    bank_load_a: assert property (ex && (op & `M_BANK) == `P_BANK
        |=> bank_select_reg == $past(op[4:0]) && $stable(zero_flag)) else $error("bad bank");
    latch_load_a: assert property (ex && (op & `M_LATCH) == `P_LATCH
        |=> pc_high_latch == $past(op[6:0]) && $stable(zero_flag)) else $error("bad latch");
    store_keep_a: assert property (ex && (op & `M_STORE) == `P_STORE
        |=> $stable(working_reg) && $stable(zero_flag)) else $error("store changed W");
    copy_back_a: assert property (ex && (op & 14'h3F80) == 14'h0880
        |=> $stable(working_reg)) else $error("copy back changed W");
    load_zero_a: assert property (ld |=> zero_flag == (working_reg == 8'h00))
        else $error("bad zero after load");
    bank_hold_a: assert property (!wr |=> $stable(bank_select_reg))
        else $error("bank moved");
    latch_hold_a: assert property (!wr |=> $stable(pc_high_latch))
        else $error("latch moved");
    cover property (ld ##1 zero_flag);
    cover property (ex && (op & `M_REL) == `P_REL);
    cover property (ex && (op & 14'h3F80) == 14'h0880);
endmodule // dm_checker

bind data_move_instruction_exec dm_checker u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .working_reg(working_reg),
    .zero_flag(zero_flag),
    .bank_select_reg(bank_select_reg),
    .pc_high_latch(pc_high_latch)
);

// ### tb/tb_top.sv
// Self-checking bench for the data-move execution block over APB.
`timescale 1ns/1ps
`include "data_move_map.vh"
module tb_top;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [31:0] rdat;
    reg [7:0] ed;
    reg err;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [7:0] working_reg;
    wire zero_flag;
    wire [4:0] bank_select_reg;
    wire [6:0] pc_high_latch;
    integer n_fail = 0;
    integer samples_checked = 0;
    integer k;

    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;

    data_move_instruction_exec u_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .working_reg(working_reg),
        .zero_flag(zero_flag),
        .bank_select_reg(bank_select_reg),
        .pc_high_latch(pc_high_latch)
    );

    task finish_test;
        begin
            $display("checks %0d, mismatches %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask

    // One APB transfer; the request holds until pready is seen high at an edge.
    task xfer(input w, input [7:0] a, input [31:0] d);
        integer i;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            for (i = 0; i < 8 && pready !== 1'b1; i = i + 1)
                @(posedge pclk);
            if (i == 8) begin
                n_fail = n_fail + 1;
                finish_test;
            end else begin
                rdat = prdata;
                err = pslverr;
                psel <= 1'b0;
                penable <= 1'b0;
                #1;
            end
        end
    endtask

    task ex(input [13:0] op);
        xfer(1'b1, `OFF_INSTR, {18'h0, op});
    endtask

    task rd(input [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    // Memory is reached through the address and data window registers.
    task poke(input [7:0] a, input [7:0] d);
        begin
            xfer(1'b1, `OFF_MEM_ADDR, {24'h0, a});
            xfer(1'b1, `OFF_MEM_DATA, {24'h0, d});
        end
    endtask

    task t_copy;
        begin
            ex(14'h305A);
            ex(14'h0090);
            xfer(1'b1, `OFF_MEM_ADDR, 32'h10);
            rd(`OFF_MEM_DATA);
            chk(rdat, 32'h5A);
            ex(14'h3000);
            ex(14'h0091);
            ex(14'h0810);
            chk(working_reg, 8'h5A);
            chk(zero_flag, 1'b0);
            ex(14'h0891);
            chk(working_reg, 8'h5A);
            chk(zero_flag, 1'b1);
            $display("test copy done");
        end
    endtask

    // Zero flag is high on entry, so any flag disturbance shows.
    task t_lit;
        begin
            ex(14'h30A5);
            chk(working_reg, 8'hA5);
            ex(14'h003F);
            chk(bank_select_reg, 5'h1F);
            ex(14'h31FF);
            chk(pc_high_latch, 7'h7F);
            ex(14'h0020);
            chk(bank_select_reg, 5'h00);
            ex(14'h0092);
            chk(working_reg, 8'hA5);
            chk(zero_flag, 1'b1);
            rd(`OFF_PCLATCH);
            chk(rdat, 32'h7F);
            chk(err, 1'b0);
            // An unmapped offset must answer with an error and leave the core alone.
            xfer(1'b1, 8'h24, 32'hFF);
            chk(err, 1'b1);
            chk(working_reg, 8'hA5);
            rd(8'h24);
            chk(err, 1'b1);
            chk(rdat, 32'h0);
            $display("test literals done");
        end
    endtask

    task t_ind;
        begin
            poke(8'h0F, 8'h11);
            for (k = 0; k < 4; k = k + 1) begin
                xfer(1'b1, `OFF_PTR1, 32'h10);
                ex({12'h005, k[1:0]});
                ed = (k == 0) ? 8'h00 : (k == 1) ? 8'h11 : 8'h5A;
                chk(working_reg, ed);
                chk(zero_flag, ed == 8'h00);
                rd(`OFF_PTR1);
                chk(rdat, k[0] ? 32'h0F : 32'h11);
            end
            xfer(1'b1, `OFF_PTR0, 32'hFFFF);
            poke(8'h7F, 8'h00);
            ex(14'h0012);
            chk(working_reg, 8'h00);
            chk(zero_flag, 1'b1);
            rd(`OFF_PTR0);
            chk(rdat, 32'h0);
            poke(8'h00, 8'h3C);
            ex(14'h0013);
            chk(working_reg, 8'h3C);
            chk(zero_flag, 1'b0);
            rd(`OFF_PTR0);
            chk(rdat, 32'hFFFF);
            xfer(1'b1, `OFF_PTR1, 32'h10);
            ex(14'h3F7F);
            chk(working_reg, 8'h11);
            poke(8'h70, 8'h77);
            ex(14'h3F60);
            chk(working_reg, 8'h77);
            rd(`OFF_PTR1);
            chk(rdat, 32'h10);
            xfer(1'b1, `OFF_PTR0, 32'h0F);
            ex(14'h0800);
            chk(working_reg, 8'h11);
            $display("test indirect done");
        end
    endtask

    // Reset is held for four cycles, then the scenarios run in order.
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_copy;
        t_lit;
        t_ind;
        finish_test;
    end
endmodule // tb_top
